// ==== logic/dpbs_pkg.sv ====
// constants, types and helpers for the dual port serial bus selector
// assumes: 32-bit apb, 18-bit serial frames per data lead
package dpbs_pkg;
  // ----------------------------------------------------------------
  // serial frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 18;
  localparam logic [4:0] FRAME_LAST = 5'h11;
  localparam logic [4:0] FRAME_CNT = 5'h12;
  localparam logic [4:0] CNT_FIRST = 5'h01;
  localparam logic [1:0] REPLY_START = 2'h2;
  // start codes {hi lead start, lo lead start}
  localparam logic [3:0] SC_WRITE_DATA = 4'h8;
  localparam logic [3:0] SC_WRITE_CMD = 4'h9;
  localparam logic [3:0] SC_READ_DATA = 4'ha;
  localparam logic [3:0] SC_SENSE = 4'hb;
  localparam logic [3:0] SC_SELECTOR = 4'hc;
  localparam logic [3:0] SC_READ_STATUS = 4'hd;
  // ----------------------------------------------------------------
  // selector command codes, bits 4..1
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_CLEAR_ERR = 4'h0;
  localparam logic [3:0] OP_MAINTENANCE_FLAG = 4'h3;
  localparam logic [3:0] OP_OPER = 4'h5;
  localparam logic [3:0] OP_GEN_MIN = 4'h9;
  // ----------------------------------------------------------------
  // status bits
  // ----------------------------------------------------------------
  localparam int ST_PERR = 0;
  localparam int ST_OVFL = 1;
  localparam int ST_SEQERR = 2;
  localparam int ST_ILLEGAL = 3;
  localparam int ST_MAINTENANCE_FLAG = 4;
  localparam int ST_PERIPHERAL_INTERRUPT = 5;
  localparam int ST_SETUP = 6;
  localparam int ST_PARITY = 7;
  localparam int ST_GEN = 8;
  localparam logic [15:0] ST_ERR_MASK = 16'h00ef;
  localparam logic [15:0] ST_GEN_MASK = 16'h0700;
  localparam logic [15:0] ST_RESET = 16'h0000;
  // ----------------------------------------------------------------
  // apb map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RECV = 3'b001,
    S_DECODE = 3'b010,
    S_EXEC = 3'b011,
    S_RELEASE = 3'b100,
    S_REPLY = 3'b101
  } dpbs_state_type;
  typedef struct packed {
    logic command_present;
    logic data_present;
    logic data_request;
    logic sense_status;
    logic end_of_block;
  } dpbs_ctrl_type;
  typedef struct packed {
    logic sync;
    logic peripheral_error;
    logic peripheral_interrupt;
    logic transfer_ready;
    logic setup;
  } dpbs_resp_type;
  typedef struct packed {
    logic valid;
    logic selcmd;
    logic rdstat;
    logic drive;
    logic capture;
    dpbs_ctrl_type ctrl;
  } dpbs_rom_type;
  // four bytes of 8 data bits plus odd parity bit
  function automatic logic [35:0] dpbs_to_bus(input logic [31:0] d);
    logic [35:0] b;
    b = 36'h0_0000_0000;
    for (int k = 0; k < 4; k++) begin
      b[9*k +: 8] = d[8*k +: 8];
      b[9*k+8] = ~^d[8*k +: 8];
    end
    return b;
  endfunction : dpbs_to_bus
  function automatic logic [31:0] dpbs_from_bus(input logic [35:0] b);
    logic [31:0] d;
    d = 32'h0000_0000;
    for (int k = 0; k < 4; k++) begin
      d[8*k +: 8] = b[9*k +: 8];
    end
    return d;
  endfunction : dpbs_from_bus
  function automatic logic dpbs_par_ok(input logic [35:0] b);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < 4; k++) begin
      ok = ok & (^b[9*k +: 9]);
    end
    return ok;
  endfunction : dpbs_par_ok
endpackage : dpbs_pkg

// ==== logic/dpbs_top.sv ====
// dual port serial bus selector: two serial ports to one parallel bus
// assumes: apb master on CLOCK_I, link clocks far slower than CLOCK_I
//
// Overview of operation
// RULE1: two independent serial ports reach one peripheral unit.
// RULE2: serial words become parallel bus words and back.
// RULE3: port has two data leads, transmit clock, receive clock, request.
// RULE4: channel supplies transmit clock at 20 or 10 MHz.
// RULE5: bus has 36 data, 5 control, 5 response leads, all active low.
// RULE6: four bytes each odd parity; whole 36-bit word even parity.
// RULE7: only 32-bit peripherals; only they may request setup.
// RULE8: command_present makes the peripheral take the word as command.
// RULE9: data_present makes the peripheral take the word as data.
// RULE10: data_request gates data, sense_status gates status onto bus.
// RULE11: end_of_block is never asserted by this path.
// RULE12: peripheral answers sync after a control, drops it after release.
// RULE13: error response sampled only once sync is seen.
// RULE14: peripheral raises interrupt when it needs attention.
// RULE15: peripheral raises transfer_ready when ready for more.
// RULE16: setup response requests controller setup, fetched by data_request.
// RULE17: two-position switch; twin start code splits high and low words.
// RULE18: rom sequencer runs operations; separate sequencer drives request.
// RULE19: selector command bit 0 is 1, marks full reception.
// RULE20: opcode 0000 clears errors, 0011 maintenance, 0101 operational.
// RULE21: opcodes 1001 to 1111 generate setup, interrupt, transfer requests.
// RULE22: 16-bit status register, bits set by internal events.
// RULE23: status bits 0 to 6 as assigned.
// RULE24: read-status command returns status to requesting port.
// RULE25: incoming data shifts into 18-bit register, start code checked.
// RULE26: only one controller connected at a time.
// RULE27: unknown opcode sets illegal-command bit only.
// RULE28: reset clears status, operational mode, releases bus controls.
`timescale 1ns/1ps
`default_nettype none
module dpbs_top (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic [7:0] PADDR_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [1:0] LINK_TXCLK_I,
  input wire logic [3:0] LINK_DATA_I,
  output logic [3:0] LINK_DATA_O,
  output logic [3:0] LINK_DATA_OE_O,
  output logic [1:0] LINK_RXCLK_O,
  output logic [1:0] LINK_REQUEST_O,
  input wire logic [35:0] BUS_DATA_N_I,
  output logic [35:0] BUS_DATA_N_O,
  output logic BUS_DATA_OE_O,
  output var dpbs_pkg::dpbs_ctrl_type BUS_CTRL_N_O,
  input wire dpbs_pkg::dpbs_resp_type BUS_RESP_N_I
);
  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic [1:0] tx_m, tx_s, tx_d;
  logic [3:0] d_m, d_s;
  logic [35:0] bus_m, bus_s;
  dpbs_pkg::dpbs_resp_type resp_m, resp_s, resp;
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      tx_m <= 2'h0;
      tx_s <= 2'h0;
      tx_d <= 2'h0;
      d_m <= 4'h0;
      d_s <= 4'h0;
      bus_m <= 36'hf_ffff_ffff;
      bus_s <= 36'hf_ffff_ffff;
      resp_m <= 5'h1f;
      resp_s <= 5'h1f;
    end else begin
      tx_m <= LINK_TXCLK_I;
      tx_s <= tx_m;
      tx_d <= tx_s;
      d_m <= LINK_DATA_I;
      d_s <= d_m;
      bus_m <= BUS_DATA_N_I;
      bus_s <= bus_m;
      resp_m <= BUS_RESP_N_I;
      resp_s <= resp_m;
    end
  end
  // bus leads are active low
  assign resp = ~resp_s; // RULE5
  logic [1:0] rise;
  assign rise = tx_s & ~tx_d;
  // ----------------------------------------------------------------
  // rom sequencer lookup
  // ----------------------------------------------------------------
  function automatic dpbs_pkg::dpbs_rom_type rom(input logic [3:0] sc);
    dpbs_pkg::dpbs_rom_type r;
    r = '0;
    r.valid = 1'b1;
    case (sc)
      dpbs_pkg::SC_WRITE_DATA: begin
        r.drive = 1'b1;
        r.ctrl.data_present = 1'b1; // RULE9
      end
      dpbs_pkg::SC_WRITE_CMD: begin
        r.drive = 1'b1;
        r.ctrl.command_present = 1'b1; // RULE8
      end
      dpbs_pkg::SC_READ_DATA: begin
        r.capture = 1'b1;
        r.ctrl.data_request = 1'b1;
      end
      dpbs_pkg::SC_SENSE: begin
        r.capture = 1'b1;
        r.ctrl.sense_status = 1'b1;
      end
      dpbs_pkg::SC_SELECTOR: r.selcmd = 1'b1;
      dpbs_pkg::SC_READ_STATUS: r.rdstat = 1'b1;
      default: r.valid = 1'b0;
    endcase
    return r;
  endfunction : rom
  // ----------------------------------------------------------------
  // main sequencer
  // ----------------------------------------------------------------
  dpbs_pkg::dpbs_state_type state_reg, state_next;
  dpbs_pkg::dpbs_rom_type op_reg, op_next, op_rd;
  logic owner_reg, owner_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [17:0] sh_hi_reg, sh_hi_next, sh_lo_reg, sh_lo_next;
  logic [31:0] loop_reg, loop_next, rep_word;
  logic [35:0] bus_o_reg, bus_o_next;
  logic bus_oe_reg, bus_oe_next;
  dpbs_pkg::dpbs_ctrl_type ctrl_n_reg, ctrl_n_next;
  logic [15:0] status_reg, status_next, st_set, st_clr;
  logic [3:0] dout_reg, dout_next, doe_reg, doe_next;
  logic [1:0] rxclk_reg, rxclk_next, req_reg, req_next, ena_reg;
  logic go_reply, hi_bit, lo_bit;
  logic [3:0] opc;
  assign hi_bit = d_s[{owner_reg, 1'b1}];
  assign lo_bit = d_s[{owner_reg, 1'b0}];
  assign opc = sh_lo_reg[4:1];
  assign op_rd = rom({sh_hi_reg[17:16], sh_lo_reg[17:16]});
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    owner_next = owner_reg;
    cnt_next = cnt_reg;
    sh_hi_next = sh_hi_reg;
    sh_lo_next = sh_lo_reg;
    loop_next = loop_reg;
    bus_o_next = bus_o_reg;
    bus_oe_next = bus_oe_reg;
    ctrl_n_next = ctrl_n_reg;
    dout_next = dout_reg;
    doe_next = doe_reg;
    rxclk_next = 2'h0;
    st_set = 16'h0000;
    st_clr = 16'h0000;
    go_reply = 1'b0;
    rep_word = {16'h0000, status_reg};
    case (state_reg)
      dpbs_pkg::S_IDLE: begin
        // port 0 wins a tie; the other waits for the next frame
        if ((ena_reg[0] && rise[0] && d_s[1]) ||
            (ena_reg[1] && rise[1] && d_s[3])) begin // RULE1 RULE26
          owner_next = !(ena_reg[0] && rise[0] && d_s[1]);
          sh_hi_next = {17'h0_0000, 1'b1};
          sh_lo_next = {17'h0_0000, owner_next ? d_s[2] : d_s[0]};
          cnt_next = dpbs_pkg::CNT_FIRST;
          state_next = dpbs_pkg::S_RECV;
        end
      end
      dpbs_pkg::S_RECV: begin
        if (rise[owner_reg]) begin // RULE25 RULE17
          sh_hi_next = {sh_hi_reg[16:0], hi_bit};
          sh_lo_next = {sh_lo_reg[16:0], lo_bit};
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == dpbs_pkg::FRAME_LAST) begin
            state_next = dpbs_pkg::S_DECODE;
          end
        end
      end
      dpbs_pkg::S_DECODE: begin
        op_next = op_rd; // RULE18
        if (!op_rd.valid) begin
          st_set[dpbs_pkg::ST_SEQERR] = 1'b1; // RULE25
          state_next = dpbs_pkg::S_IDLE;
        end else if (op_rd.selcmd) begin
          go_reply = 1'b1;
          if (!sh_lo_reg[0]) begin
            st_set[dpbs_pkg::ST_ILLEGAL] = 1'b1; // RULE19
          end else if (opc == dpbs_pkg::OP_CLEAR_ERR) begin
            st_clr = dpbs_pkg::ST_ERR_MASK; // RULE20
          end else if (opc == dpbs_pkg::OP_MAINTENANCE_FLAG) begin
            st_set[dpbs_pkg::ST_MAINTENANCE_FLAG] = 1'b1; // RULE20
          end else if (opc == dpbs_pkg::OP_OPER) begin
            st_clr[dpbs_pkg::ST_MAINTENANCE_FLAG] = 1'b1; // RULE20
          end else if (opc >= dpbs_pkg::OP_GEN_MIN) begin
            st_set[dpbs_pkg::ST_GEN +: 3] = opc[2:0]; // RULE21
          end else begin
            st_set[dpbs_pkg::ST_ILLEGAL] = 1'b1; // RULE27
          end
        end else if (op_rd.rdstat) begin
          go_reply = 1'b1; // RULE24
          st_clr = dpbs_pkg::ST_GEN_MASK;
        end else if (status_reg[dpbs_pkg::ST_MAINTENANCE_FLAG]) begin
          // loop around, peripheral untouched
          go_reply = 1'b1;
          if (op_rd.drive) begin
            loop_next = {sh_hi_reg[15:0], sh_lo_reg[15:0]};
          end
          rep_word = op_rd.capture ? loop_reg : rep_word;
        end else begin
          bus_o_next = ~dpbs_pkg::dpbs_to_bus(
            {sh_hi_reg[15:0], sh_lo_reg[15:0]}); // RULE2 RULE6
          bus_oe_next = op_rd.drive;
          ctrl_n_next = ~op_rd.ctrl; // RULE8 RULE9 RULE11
          state_next = dpbs_pkg::S_EXEC;
        end
      end
      dpbs_pkg::S_EXEC: begin
        if (resp.sync) begin // RULE12
          // error is valid only once sync is up
          st_set[dpbs_pkg::ST_PERR] = resp.peripheral_error; // RULE13
          if (op_reg.capture) begin
            loop_next = dpbs_pkg::dpbs_from_bus(~bus_s); // RULE2
            st_set[dpbs_pkg::ST_PARITY] =
              !dpbs_pkg::dpbs_par_ok(~bus_s); // RULE6
          end
          ctrl_n_next = 5'h1f;
          state_next = dpbs_pkg::S_RELEASE;
        end
      end
      dpbs_pkg::S_RELEASE: begin
        if (!resp.sync) begin // RULE12
          bus_oe_next = 1'b0;
          go_reply = 1'b1;
          rep_word = op_reg.capture ? loop_reg : rep_word;
        end
      end
      dpbs_pkg::S_REPLY: begin
        rxclk_next[owner_reg] = tx_s[owner_reg]; // RULE3
        if (rise[owner_reg]) begin
          if (cnt_reg == dpbs_pkg::FRAME_CNT) begin
            doe_next = 4'h0;
            dout_next = 4'h0;
            state_next = dpbs_pkg::S_IDLE;
          end else begin
            dout_next = 4'h0;
            dout_next[{owner_reg, 1'b1}] = sh_hi_reg[17];
            dout_next[{owner_reg, 1'b0}] = sh_lo_reg[17];
            sh_hi_next = {sh_hi_reg[16:0], 1'b0};
            sh_lo_next = {sh_lo_reg[16:0], 1'b0};
            cnt_next = cnt_reg + 5'h01;
          end
        end
      end
      default: state_next = dpbs_pkg::S_IDLE;
    endcase
    if (go_reply) begin // RULE24 RULE2
      sh_hi_next = {dpbs_pkg::REPLY_START, rep_word[31:16]};
      sh_lo_next = {dpbs_pkg::REPLY_START, rep_word[15:0]};
      cnt_next = 5'h00;
      doe_next = 4'h0;
      doe_next[{owner_reg, 1'b1}] = 1'b1;
      doe_next[{owner_reg, 1'b0}] = 1'b1;
      state_next = dpbs_pkg::S_REPLY;
    end
    // frame start on owning port while busy
    if (state_reg != dpbs_pkg::S_IDLE && state_reg != dpbs_pkg::S_RECV &&
        state_reg != dpbs_pkg::S_REPLY && rise[owner_reg] && hi_bit) begin
      st_set[dpbs_pkg::ST_OVFL] = 1'b1;
    end
    st_set[dpbs_pkg::ST_PERIPHERAL_INTERRUPT] = resp.peripheral_interrupt; // RULE23
    st_set[dpbs_pkg::ST_SETUP] = resp.setup; // RULE7 RULE16
    // set wins over clear
    status_next = (status_reg & ~st_clr) | st_set; // RULE22
    // request sequencer, toward the owning port only
    req_next = 2'h0;
    req_next[owner_reg] = |(status_reg & dpbs_pkg::ST_GEN_MASK) ||
      resp.peripheral_interrupt || resp.transfer_ready ||
      resp.setup; // RULE18 RULE26
  end
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg <= dpbs_pkg::S_IDLE;
      op_reg <= '0;
      owner_reg <= 1'b0;
      cnt_reg <= 5'h00;
      sh_hi_reg <= 18'h0_0000;
      sh_lo_reg <= 18'h0_0000;
      loop_reg <= 32'h0000_0000;
      bus_o_reg <= 36'hf_ffff_ffff;
      bus_oe_reg <= 1'b0;
      ctrl_n_reg <= 5'h1f; // RULE28
      status_reg <= dpbs_pkg::ST_RESET; // RULE28
      dout_reg <= 4'h0;
      doe_reg <= 4'h0;
      rxclk_reg <= 2'h0;
      req_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      owner_reg <= owner_next;
      cnt_reg <= cnt_next;
      sh_hi_reg <= sh_hi_next;
      sh_lo_reg <= sh_lo_next;
      loop_reg <= loop_next;
      bus_o_reg <= bus_o_next;
      bus_oe_reg <= bus_oe_next;
      ctrl_n_reg <= ctrl_n_next;
      status_reg <= status_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      rxclk_reg <= rxclk_next;
      req_reg <= req_next;
    end
  end
  // ----------------------------------------------------------------
  // apb slave, one wait state
  // ----------------------------------------------------------------
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [1:0] ena_next;
  always_comb begin
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    pready_next = 1'b0;
    ena_next = ena_reg;
    if (PSEL_I && PENABLE_I && !pready_reg) begin
      pready_next = 1'b1;
      case (PADDR_I)
        dpbs_pkg::OFS_STATUS: prdata_next = {16'h0000, status_reg};
        dpbs_pkg::OFS_CTRL: prdata_next = {30'h0000_0000, ena_reg};
        default: begin
          prdata_next = 32'h0000_0000;
          pslverr_next = 1'b1;
        end
      endcase
    end
    if (PSEL_I && PENABLE_I && pready_reg && PWRITE_I &&
        PADDR_I == dpbs_pkg::OFS_CTRL) begin
      ena_next = PWDATA_I[1:0];
    end
  end
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      ena_reg <= dpbs_pkg::CTRL_RESET;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      ena_reg <= ena_next;
    end
  end
  assign PRDATA_O = prdata_reg;
  assign PREADY_O = pready_reg;
  assign PSLVERR_O = pslverr_reg;
  assign LINK_DATA_O = dout_reg;
  assign LINK_DATA_OE_O = doe_reg;
  assign LINK_RXCLK_O = rxclk_reg;
  assign LINK_REQUEST_O = req_reg;
  assign BUS_DATA_N_O = bus_o_reg;
  assign BUS_DATA_OE_O = bus_oe_reg;
  assign BUS_CTRL_N_O = ctrl_n_reg;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  AST_ONE_PORT: assert property ( // RULE26
    !(doe_reg[1:0] != 2'h0 && doe_reg[3:2] != 2'h0))
    else $error("both ports driven");
  AST_NO_EOB: assert property (ctrl_n_reg.end_of_block) // RULE11
    else $error("end_of_block asserted");
  AST_ONE_CTRL: assert property ($onehot0(~ctrl_n_reg)) // RULE8
    else $error("more than one control");
  AST_BUS_PARITY: assert property (bus_oe_reg |-> !(^bus_o_reg)) // RULE6
    else $error("bus word parity odd");
  AST_ILLEGAL: assert property ( // RULE27
    state_reg == dpbs_pkg::S_DECODE && op_rd.selcmd && sh_lo_reg[0] &&
    (opc == 4'h8 || opc == 4'h1) |=>
    status_reg[dpbs_pkg::ST_ILLEGAL] && state_reg == dpbs_pkg::S_REPLY)
    else $error("illegal opcode not flagged");
  AST_GEN_ALL: assert property ( // RULE21
    state_reg == dpbs_pkg::S_DECODE && op_rd.selcmd &&
    sh_lo_reg[4:0] == 5'h1f |=> status_reg[dpbs_pkg::ST_GEN +: 3] == 3'h7)
    else $error("requests not generated");
  AST_ERR_AFTER_SYNC: assert property ( // RULE13
    $rose(status_reg[dpbs_pkg::ST_PERR]) |->
    $past(state_reg) == dpbs_pkg::S_EXEC && $past(resp.sync))
    else $error("error sampled without sync");
  AST_CTRL_HOLD: assert property ( // RULE12
    $fell(ctrl_n_reg != 5'h1f) |-> $past(resp.sync) ##1
    state_reg == dpbs_pkg::S_RELEASE)
    else $error("control dropped before sync");
  // loopback mode must never touch the peripheral, in any state
  AST_MAINTENANCE_FLAG_QUIET: assert property ( // RULE20
    status_reg[dpbs_pkg::ST_MAINTENANCE_FLAG] |-> ctrl_n_reg == 5'h1f)
    else $error("control active in maintenance");
  COV_WRITE: cover property (!ctrl_n_reg.data_present ##[1:50] resp.sync);
  COV_READ: cover property (!ctrl_n_reg.data_request ##[1:50]
    state_reg == dpbs_pkg::S_REPLY);
  COV_SEL: cover property (state_reg == dpbs_pkg::S_DECODE && op_rd.selcmd);
  COV_PORT1: cover property (owner_reg && state_reg == dpbs_pkg::S_REPLY);
endmodule : dpbs_top
`default_nettype wire

// ==== verification/dpbs_periph_model.sv ====
// peripheral unit model: answers each control with a sync handshake
// assumes: active-low bus; the bench resolves the shared data wire
`timescale 1ns/1ps
`default_nettype none
module dpbs_periph_model (
  input wire logic clk_i,
  input wire dpbs_pkg::dpbs_ctrl_type ctrl_n_i,
  input wire logic [35:0] wire_n_i,
  input wire logic [35:0] rd_i,
  input wire logic [3:0] lvl_i,
  output var dpbs_pkg::dpbs_resp_type resp_n_o,
  output logic [35:0] drv_n_o,
  output logic drv_o,
  output logic [4:0] last_o,
  output logic [35:0] cap_o
);
  logic [4:0] act;
  logic [2:0] dly;
  logic sync = 1'b0;
  assign act = ~ctrl_n_i;
  assign drv_n_o = ~rd_i;
  // levels {error, interrupt, transfer, setup} come from the bench
  assign resp_n_o = {~sync, ~lvl_i};
  // ----------
  // handshake
  // ----------
  // slow on purpose: sync only after five cycles of a held control
  always @(posedge clk_i) begin
    if (act == 5'h00) begin
      dly <= 3'h0;
      sync <= 1'b0;
      drv_o <= 1'b0;
    end else if (!sync) begin
      dly <= dly + 3'h1;
      drv_o <= act[2] | act[1];
      if (dly == 3'h4) begin
        sync <= 1'b1;
        last_o <= act;
        cap_o <= ~wire_n_i;
      end
    end
  end
endmodule : dpbs_periph_model
`default_nettype wire

// ==== verification/dpbs_top_test.sv ====
// bench for the dual port serial bus selector: apb, both ports, bus
// assumes: peripheral model on the bus; bench drives both serial ports
`timescale 1ns/1ps
`default_nettype none
module dpbs_top_test;
  localparam logic [29:0] sel_tab = {5'h01, 5'h03, 5'h01, 5'h06,
    5'h0b, 5'h07};
  localparam logic [19:0] msk = {5'h02, 5'h04, 5'h10, 5'h08};
  logic clk, rst, psel, pen, pwr, pready, pslverr, perr, drv, boe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdw, rep, ex;
  logic [1:0] txclk, rxclk, req;
  logic [3:0] tbl, ldo, loe, lw, lvl, cyc;
  logic [35:0] bdo, bw, pdrv, cap, rdv;
  logic [4:0] last;
  dpbs_pkg::dpbs_ctrl_type ctl;
  dpbs_pkg::dpbs_resp_type rsp;
  int bad_count, compares, nb, nr;
  // released bus lines show a moving pattern, never a held value
  assign lw = (loe & ldo) | (~loe & tbl);
  assign bw = boe ? bdo : (drv ? pdrv : {9{cyc}});
  dpbs_top dpbs_top_i (.CLOCK_I(clk), .RST_I(rst), .PADDR_I(paddr),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .LINK_TXCLK_I(txclk), .LINK_DATA_I(lw), .LINK_DATA_O(ldo),
    .LINK_DATA_OE_O(loe), .LINK_RXCLK_O(rxclk), .LINK_REQUEST_O(req),
    .BUS_DATA_N_I(bw), .BUS_DATA_N_O(bdo), .BUS_DATA_OE_O(boe),
    .BUS_CTRL_N_O(ctl), .BUS_RESP_N_I(rsp));
  dpbs_periph_model dpbs_periph_model_i (.clk_i(clk), .ctrl_n_i(ctl),
    .wire_n_i(bw), .rd_i(rdv), .lvl_i(lvl), .resp_n_o(rsp),
    .drv_n_o(pdrv), .drv_o(drv), .last_o(last), .cap_o(cap));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 4'h1;
  // ----------
  // tasks
  // ----------
  function automatic logic [35:0] enc(input logic [31:0] d);
    logic [35:0] b;
    for (int k = 0; k < 4; k++)
      b[9*k +: 9] = {~^d[8*k +: 8], d[8*k +: 8]};
    return b;
  endfunction : enc
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // pready read at the rising edge, before the slave updates it
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      test_done();
    end
    rdw = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
      input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    chk({3'h0, perr, rdw}, {3'h0, ee, e});
  endtask : rc
  // link clock stands still between frames; reply bits taken on its fall
  task automatic frame(input int p, input logic [3:0] sc,
      input logic [31:0] w);
    logic [17:0] hi, lo, rh, rl;
    hi = {sc[3:2], w[31:16]};
    lo = {sc[1:0], w[15:0]};
    nb = 0;
    nr = 0;
    for (int i = 17; i >= 0; i--) begin
      tbl[2*p+1] = hi[i];
      tbl[2*p] = lo[i];
      #62.5 txclk[p] = 1'b1;
      #62.5 txclk[p] = 1'b0;
    end
    tbl[2*p+1] = 1'b0;
    tbl[2*p] = ~lo[0];
    // clock held still until the reply enables rise, so no edge is lost
    for (int n = 0; n < 300 && loe[2*p+1] !== 1'b1; n++)
      @(posedge clk);
    for (int n = 0; n < 19 && loe[2*p+1] === 1'b1; n++) begin
      #62.5 txclk[p] = 1'b1;
      #62.5 txclk[p] = 1'b0;
      if (loe[2*p+1] === 1'b1) begin
        rh = {rh[16:0], lw[2*p+1]};
        rl = {rl[16:0], lw[2*p]};
        nb++;
        if (rxclk[p] === 1'b1) nr++;
      end
    end
    rep = {rh[15:0], rl[15:0]};
    if (nb > 0) chk(36'({rh[17:16], rl[17:16]}), 36'h0_0000_000a);
  endtask : frame
  task automatic xf(input int p, input logic [3:0] sc, input logic [31:0] w,
      input int en, input logic [31:0] er);
    frame(p, sc, w);
    chk(36'(nb), 36'(18 * en));
    chk(36'(nr), 36'(18 * en));
    if (en != 0) chk(36'(rep), 36'(er));
  endtask : xf
  // ----------
  // sequence
  // ----------
  initial begin
    rst = 1'b1;
    {psel, pen, pwr, paddr, pwdata} = '0;
    txclk = 2'h0;
    tbl = 4'h0;
    lvl = 4'h0;
    rdv = 36'h0_0000_0000;
    cyc = 4'h0;
    bad_count = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(36'(ctl), 36'h0_0000_001f);
    rc(8'h00, 32'h0000_0000, 1'b0);
    rc(8'h04, 32'h0000_0003, 1'b0);
    rc(8'h08, 32'h0000_0000, 1'b1);
    apb(1'b1, 8'h00, 32'hffff_ffff);
    rc(8'h00, 32'h0000_0000, 1'b0);
    apb(1'b1, 8'h04, 32'h0000_0001);
    xf(1, 4'hc, 32'h0000_001f, 0, 32'h0000_0000);
    rc(8'h00, 32'h0000_0000, 1'b0);
    apb(1'b1, 8'h04, 32'h0000_0003);
    // a selector reply carries the status from before its command
    for (int i = 0; i < 6; i++) begin
      ex = (i == 1) ? 32'h0000_0010 : ((i % 2) ? 32'h0000_0008 : 32'h0000_0000);
      xf(i % 2, 4'hc, 32'(sel_tab[5*i +: 5]), 1, ex);
    end
    for (int op = 9; op < 16; op++) begin
      ex = 32'(op % 8) << 8;
      xf(op % 2, 4'hc, 32'(op * 2 + 1), 1, 32'h0000_0000);
      chk(36'(|req), 36'h0_0000_0001);
      xf(op % 2, 4'hd, 32'h0000_0000, 1, ex);
      chk(36'(req), 36'h0_0000_0000);
    end
    rdv = enc(32'h8765_4321);
    for (int k = 0; k < 4; k++) begin
      ex = k < 2 ? 32'h0000_0000 : 32'h8765_4321;
      xf(0, 4'h8 + 4'(k), 32'h1234_5678 + 32'(k), 1, ex);
      chk(36'(last), 36'(msk[5*k +: 5]));
      if (k < 2) chk(cap, enc(32'h1234_5678 + 32'(k)));
      if (k < 2) chk(36'(^cap), 36'h0_0000_0000);
    end
    @(posedge clk);
    lvl <= 4'h8;
    repeat (8) @(posedge clk);
    rc(8'h00, 32'h0000_0000, 1'b0);
    xf(0, 4'h8, 32'h0000_0000, 1, 32'h0000_0001);
    @(posedge clk);
    lvl <= 4'h7;
    repeat (8) @(posedge clk);
    rc(8'h00, 32'h0000_0061, 1'b0);
    chk(36'(|req), 36'h0_0000_0001);
    lvl <= 4'h0;
    xf(0, 4'hc, 32'h0000_0001, 1, 32'h0000_0061);
    chk(36'(req), 36'h0_0000_0000);
    xf(0, 4'he, 32'h0000_0000, 0, 32'h0000_0000);
    rc(8'h00, 32'h0000_0004, 1'b0);
    xf(0, 4'hc, 32'h0000_0007, 1, 32'h0000_0004);
    xf(0, 4'h8, 32'habcd_0123, 1, 32'h0000_0014);
    xf(0, 4'ha, 32'h0000_0000, 1, 32'habcd_0123);
    chk(36'(last), 36'h0_0000_0008);
    xf(0, 4'hc, 32'h0000_000b, 1, 32'h0000_0014);
    xf(0, 4'hc, 32'h0000_0001, 1, 32'h0000_0004);
    test_done();
  end
endmodule : dpbs_top_test
`default_nettype wire
